// file: src/tsq_pkg.sv
package tsq_pkg;

    // Bus geometry: byte addresses, one aligned 32-bit word per register.
    localparam int TSQ_ADDR_W = 6;
    localparam int TSQ_DATA_W = 32;
    localparam int TSQ_BE_W = 4;

    // Register byte offsets.
    localparam logic [5:0] TSQ_OFF_POINTER = 6'h00;
    localparam logic [5:0] TSQ_OFF_QUEUE_FIRST = 6'h04;
    localparam logic [5:0] TSQ_OFF_QUEUE_LAST = 6'h20;
    localparam logic [5:0] TSQ_OFF_CONTROL = 6'h24;

    // Field layout.
    localparam int TSQ_PTR_W = 5;
    localparam int TSQ_BYTE_W = 8;
    localparam int TSQ_HALF_W = 16;
    localparam int TSQ_QUEUE_WORDS = 8;
    localparam int TSQ_STEP_COUNT = 16;
    localparam int TSQ_QIDX_W = 3;
    localparam int TSQ_SIDX_W = 4;
    localparam int TSQ_CTRL_ENABLE_BIT = 0;
    localparam int TSQ_CTRL_START_BIT = 1;

    // Reset values.
    localparam logic [4:0] TSQ_PTR_RESET = 5'h00;
    localparam logic TSQ_CTRL_RESET = 1'b0;
    localparam logic [31:0] TSQ_RDATA_RESET = 32'h0000_0000;
    localparam logic [7:0] TSQ_CMD_RESET = 8'h00;

    // True when the byte address falls on one of the eight queue words.
    function automatic logic tsqIsQueue(input logic [5:0] addr);
        logic [5:0] word;
        word = {addr[5:2], 2'b00};
        return (word >= TSQ_OFF_QUEUE_FIRST) && (word <= TSQ_OFF_QUEUE_LAST);
    endfunction

    // Queue word index 0..7 for a queue byte address.
    function automatic logic [2:0] tsqQueueIndex(input logic [5:0] addr);
        logic [5:0] diff;
        diff = {addr[5:2], 2'b00} - TSQ_OFF_QUEUE_FIRST;
        return diff[4:2];
    endfunction

endpackage

// file: src/tsq_step_pointer.sv
`timescale 1ns/1ps
module tsq_step_pointer
    import tsq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic loadEn,
    input wire logic [4:0] loadValue,
    input wire logic advanceEn,
    // State
    output logic [4:0] pointer
);

    logic [4:0] pointer_reg;
    logic [4:0] pointer_next;

    always_comb
    begin
        pointer_next = pointer_reg;
        if (loadEn)
        begin
            pointer_next = loadValue;
        end
        else if (advanceEn)
        begin
            pointer_next = 5'(pointer_reg + 5'h01);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pointer_reg <= TSQ_PTR_RESET;
        end
        else
        begin
            pointer_reg <= pointer_next;
        end
    end

    assign pointer = pointer_reg;

    a_pointer_advance_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        (advanceEn && !loadEn) |=> (pointer_reg == 5'($past(pointer_reg) + 5'h01)))
        else $error("Pointer did not advance by one step.");

endmodule // tsq_step_pointer

// file: src/tsq_queue_store.sv
`timescale 1ns/1ps
module tsq_queue_store
    import tsq_pkg::*;
(
    // Clock and reset; reset only quiets the checks, the bytes never clear
    input wire logic core_clk,
    input wire logic rst_n,
    // Write port
    input wire logic wrEn,
    input wire logic [2:0] wrIndex,
    input wire logic [1:0] wrByteEn,
    input wire logic [15:0] wrWord,
    // Bus read port
    input wire logic [2:0] rdIndex,
    output logic [15:0] rdWord,
    // Step read port
    input wire logic [3:0] stepIndex,
    output logic [7:0] stepByte
);

    // No reset term: the command bytes must survive every reset.
    logic [7:0] stepMem [TSQ_STEP_COUNT];

    always_ff @(posedge core_clk)
    begin
        if (wrEn && wrByteEn[0])
        begin
            stepMem[{wrIndex, 1'b0}] <= wrWord[7:0];
        end
        if (wrEn && wrByteEn[1])
        begin
            stepMem[{wrIndex, 1'b1}] <= wrWord[15:8];
        end
    end

    assign rdWord = {stepMem[{rdIndex, 1'b1}], stepMem[{rdIndex, 1'b0}]};
    assign stepByte = stepMem[stepIndex];

    a_even_byte_store: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrEn && wrByteEn[0]) |=> (stepMem[{$past(wrIndex), 1'b0}] == $past(wrWord[7:0])))
        else $error("Even step byte not stored in low byte.");

    a_odd_byte_store: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrEn && wrByteEn[1]) |=> (stepMem[{$past(wrIndex), 1'b1}] == $past(wrWord[15:8])))
        else $error("Odd step byte not stored in high byte.");

endmodule // tsq_queue_store

// file: src/tsq_trigger_step_queue_store.sv
`timescale 1ns/1ps
module tsq_trigger_step_queue_store
    import tsq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Step executor side
    input wire logic stepAdvance,
    output logic [7:0] stepCommand,
    output logic [4:0] stepPointer,
    // Generator state
    output logic generatorEnable,
    output logic sequenceStart,
    output logic queueLocked
);

    logic busReq;
    logic busAccept;
    logic wrAccept;
    logic hitPointer;
    logic hitQueue;
    logic hitControl;
    logic [2:0] queueIdx;

    logic waitReq_reg;
    logic waitReq_next;
    logic [31:0] readData_reg;
    logic [31:0] readData_next;
    logic enable_reg;
    logic enable_next;
    logic start_reg;
    logic start_next;
    logic locked_reg;
    logic locked_next;
    logic [7:0] stepCmd_reg;

    logic ptrLoadEn;
    logic ptrAdvanceEn;
    logic [4:0] ptrValue;
    logic queueWrEn;
    logic [15:0] queueRdWord;
    logic [7:0] queueStepByte;

    // Address decode; the low two address bits select nothing.
    assign hitPointer = ({avs_address[5:2], 2'b00} == TSQ_OFF_POINTER);
    assign hitControl = ({avs_address[5:2], 2'b00} == TSQ_OFF_CONTROL);
    assign hitQueue = tsqIsQueue(avs_address);
    assign queueIdx = tsqQueueIndex(avs_address);

    // A request is held for one wait cycle, then completed at the edge where
    // waitrequest is seen low. That single fixed wait lets read data come from
    // a flop without a pipeline of its own.
    assign busReq = avs_read || avs_write;
    assign busAccept = busReq && !waitReq_reg;
    assign wrAccept = busAccept && avs_write;

    always_comb
    begin
        waitReq_next = 1'b1;
        if (busReq && waitReq_reg)
        begin
            waitReq_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitReq_reg <= 1'b1;
        end
        else
        begin
            waitReq_reg <= waitReq_next;
        end
    end

    // Read data is captured as waitrequest drops and stands until the next read.
    always_comb
    begin
        readData_next = readData_reg;
        if (avs_read && waitReq_reg)
        begin
            readData_next = TSQ_RDATA_RESET;
            if (hitPointer)
            begin
                readData_next[TSQ_PTR_W-1:0] = ptrValue;
            end
            else if (hitQueue)
            begin
                readData_next[TSQ_HALF_W-1:0] = queueRdWord;
            end
            else if (hitControl)
            begin
                readData_next[TSQ_CTRL_ENABLE_BIT] = enable_reg;
                readData_next[TSQ_CTRL_START_BIT] = start_reg;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            readData_reg <= TSQ_RDATA_RESET;
        end
        else
        begin
            readData_reg <= readData_next;
        end
    end

    // Control bits stay writable while locked, otherwise software could never stop
    // the generator to reload the queue.
    always_comb
    begin
        enable_next = enable_reg;
        start_next = start_reg;
        if (wrAccept && hitControl && avs_byteenable[0])
        begin
            enable_next = avs_writedata[TSQ_CTRL_ENABLE_BIT];
            start_next = avs_writedata[TSQ_CTRL_START_BIT];
        end
        locked_next = enable_next && start_next;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_reg <= TSQ_CTRL_RESET;
            start_reg <= TSQ_CTRL_RESET;
            locked_reg <= TSQ_CTRL_RESET;
        end
        else
        begin
            enable_reg <= enable_next;
            start_reg <= start_next;
            locked_reg <= locked_next;
        end
    end

    // Pointer and queue writes pass only while the generator is not running.
    assign ptrLoadEn = wrAccept && hitPointer && avs_byteenable[0] && !locked_reg;
    assign queueWrEn = wrAccept && hitQueue && !locked_reg;
    assign ptrAdvanceEn = stepAdvance && locked_reg;

    tsq_step_pointer u_pointer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .loadEn(ptrLoadEn),
        .loadValue(avs_writedata[TSQ_PTR_W-1:0]),
        .advanceEn(ptrAdvanceEn),
        .pointer(ptrValue)
    );

    tsq_queue_store u_store (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wrEn(queueWrEn),
        .wrIndex(queueIdx),
        .wrByteEn(avs_byteenable[1:0]),
        .wrWord(avs_writedata[TSQ_HALF_W-1:0]),
        .rdIndex(queueIdx),
        .rdWord(queueRdWord),
        .stepIndex(ptrValue[TSQ_SIDX_W-1:0]),
        .stepByte(queueStepByte)
    );

    // The command byte lags the pointer by one cycle; the executor must allow for it.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stepCmd_reg <= TSQ_CMD_RESET;
        end
        else
        begin
            stepCmd_reg <= queueStepByte;
        end
    end

    assign avs_readdata = readData_reg;
    assign avs_waitrequest = waitReq_reg;
    assign stepCommand = stepCmd_reg;
    assign stepPointer = ptrValue;
    assign generatorEnable = enable_reg;
    assign sequenceStart = start_reg;
    assign queueLocked = locked_reg;

    // A second copy of the pointer, built from the bus and executor inputs plus the accept and lock flags, so
    // that a wrong enable or a fault inside the pointer module shows up as a mismatch.
    logic [4:0] ptrShadow_reg;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptrShadow_reg <= TSQ_PTR_RESET;
        end
        else if (wrAccept && hitPointer && avs_byteenable[0] && !queueLocked)
        begin
            ptrShadow_reg <= avs_writedata[TSQ_PTR_W-1:0];
        end
        else if (stepAdvance && queueLocked)
        begin
            ptrShadow_reg <= 5'(ptrShadow_reg + 5'h01);
        end
    end

    a_wait_single_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
        (busReq && avs_waitrequest) |=> !avs_waitrequest)
        else $error("Request not answered after one wait cycle.");

    a_pointer_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (avs_read && hitPointer && !avs_waitrequest) |-> (avs_readdata[31:TSQ_PTR_W] == 27'h0000000))
        else $error("Upper pointer register bits read nonzero.");

    a_pointer_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrAccept && hitPointer && avs_byteenable[0] && !locked_reg)
        |=> (stepPointer == $past(avs_writedata[4:0])))
        else $error("Unlocked pointer write did not land.");

    a_lock_pointer_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrAccept && hitPointer && generatorEnable && sequenceStart && !stepAdvance)
        |=> (stepPointer == $past(stepPointer)))
        else $error("Pointer changed by a write while locked.");

    a_lock_queue_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrAccept && hitQueue && generatorEnable && sequenceStart) |-> !queueWrEn)
        else $error("Queue write passed while locked.");

    a_lock_tracks_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
        queueLocked == (generatorEnable && sequenceStart))
        else $error("Lock flag disagrees with enable and start.");

    a_queue_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrAccept && hitQueue && !locked_reg && (avs_byteenable[1:0] == 2'h3))
        ##1 (avs_read && waitReq_reg && (queueIdx == $past(queueIdx)))
        |=> (avs_readdata[15:0] == $past(avs_writedata[15:0], 2)))
        else $error("Queue word did not read back as written.");

    a_wait_idle_high: assert property (@(posedge core_clk) disable iff (!rst_n)
        !busReq
        |=> avs_waitrequest)
        else $error("Waitrequest dropped with no request.");

    a_wait_one_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        !avs_waitrequest
        |=> avs_waitrequest)
        else $error("Waitrequest stayed low for more than one cycle.");

    a_wait_after_request: assert property (@(posedge core_clk) disable iff (!rst_n)
        !avs_waitrequest
        |-> $past(busReq))
        else $error("Waitrequest low without a request in the cycle before.");

    a_readdata_stands: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(avs_read && avs_waitrequest)
        |=> $stable(avs_readdata))
        else $error("Read data changed outside a read answer.");

    a_pointer_read_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        (avs_read && hitPointer && !avs_waitrequest)
        |-> (avs_readdata[TSQ_PTR_W-1:0] == $past(stepPointer)))
        else $error("Pointer read did not return the pointer.");

    a_queue_read_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        (avs_read && hitQueue && !avs_waitrequest)
        |-> (avs_readdata[TSQ_HALF_W-1:0] == $past(queueRdWord)))
        else $error("Queue read did not return the stored bytes.");

    a_queue_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (avs_read && hitQueue && !avs_waitrequest)
        |-> (avs_readdata[31:TSQ_HALF_W] == 16'h0000))
        else $error("Upper queue word bits read nonzero.");

    a_unmapped_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (avs_read && !hitPointer && !hitQueue && !hitControl && !avs_waitrequest)
        |-> (avs_readdata == 32'h0000_0000))
        else $error("Unmapped address read nonzero.");

    a_control_read_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        (avs_read && hitControl && !avs_waitrequest)
        |-> (avs_readdata == {30'h0000_0000, $past(sequenceStart), $past(generatorEnable)}))
        else $error("Control read did not return enable and start.");

    a_control_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrAccept && hitControl && avs_byteenable[0])
        |=> ((generatorEnable == $past(avs_writedata[TSQ_CTRL_ENABLE_BIT]))
            && (sequenceStart == $past(avs_writedata[TSQ_CTRL_START_BIT]))))
        else $error("Control write did not land.");

    a_control_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(wrAccept && hitControl && avs_byteenable[0])
        |=> ($stable(generatorEnable) && $stable(sequenceStart)))
        else $error("Control bits changed without a control write.");

    a_idle_pointer_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!stepAdvance && !(wrAccept && hitPointer))
        |=> $stable(stepPointer))
        else $error("Pointer moved with no write and no advance.");

    a_unlocked_no_advance: assert property (@(posedge core_clk) disable iff (!rst_n)
        (stepAdvance && !queueLocked && !(wrAccept && hitPointer))
        |=> $stable(stepPointer))
        else $error("Pointer advanced while the generator was not running.");

    a_pointer_lane_guard: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrAccept && hitPointer && !avs_byteenable[0] && !stepAdvance)
        |=> $stable(stepPointer))
        else $error("Pointer written without its byte lane.");

    a_step_pointer_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ptrAdvanceEn && (stepPointer == 5'h1F))
        |=> (stepPointer == 5'h00))
        else $error("Pointer did not wrap to zero.");

    a_lock_write_acked: assert property (@(posedge core_clk) disable iff (!rst_n)
        (avs_write && avs_waitrequest && queueLocked)
        |=> !avs_waitrequest)
        else $error("Write while locked was not acknowledged.");

    a_pointer_shadow_match: assert property (@(posedge core_clk) disable iff (!rst_n)
        (stepPointer == ptrShadow_reg))
        else $error("Pointer disagrees with its shadow copy.");

endmodule // tsq_trigger_step_queue_store

// file: bench/tsq_trigger_step_queue_store_bench.sv
`timescale 1ns/1ps
module tsq_trigger_step_queue_store_bench;
    import tsq_pkg::*;

    logic core_clk;
    logic rst_n;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic stepAdvance;
    logic [7:0] stepCommand;
    logic [4:0] stepPointer;
    logic generatorEnable;
    logic sequenceStart;
    logic queueLocked;
    int err_total = 0;
    int checked = 0;
    int seed = 86397;
    int ptrModel = 0;
    logic [7:0] stepModel [16];
    logic enModel = 1'b0;
    logic startModel = 1'b0;

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    tsq_trigger_step_queue_store dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stepAdvance(stepAdvance),
        .stepCommand(stepCommand), .stepPointer(stepPointer), .generatorEnable(generatorEnable),
        .sequenceStart(sequenceStart), .queueLocked(queueLocked)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [31:0] model_read(input logic [5:0] a);
        if (a == TSQ_OFF_POINTER)
            return {27'h0, ptrModel[4:0]};
        if (a >= TSQ_OFF_QUEUE_FIRST && a <= TSQ_OFF_QUEUE_LAST)
            return {16'h0, stepModel[a / 2 - 1], stepModel[a / 2 - 2]};
        if (a == TSQ_OFF_CONTROL)
            return {30'h0, startModel, enModel};
        return 32'h0;
    endfunction

    // The request is sampled against waitrequest at the edge, before that edge's updates land.
    task automatic wait_ack();
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40)
            check("waitrequest", {31'h0, avs_waitrequest}, 32'h0);
    endtask

    task automatic bus_write(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        if (a == TSQ_OFF_CONTROL && be[0])
        begin
            enModel = d[0];
            startModel = d[1];
        end
        else if (!(enModel && startModel))
        begin
            if (a == TSQ_OFF_POINTER && be[0])
                ptrModel = d[4:0];
            if (a >= TSQ_OFF_QUEUE_FIRST && a <= TSQ_OFF_QUEUE_LAST && be[0])
                stepModel[a / 2 - 2] = d[7:0];
            if (a >= TSQ_OFF_QUEUE_FIRST && a <= TSQ_OFF_QUEUE_LAST && be[1])
                stepModel[a / 2 - 1] = d[15:8];
        end
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask

    task automatic read_check(input logic [5:0] a);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_ack();
        check($sformatf("readdata at %h", a), avs_readdata, model_read(a));
        avs_read <= 1'b0;
    endtask

    // Read at once after the write, with no idle edge between, at the same address.
    task automatic write_read(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        bus_write(a, d, be);
        avs_read <= 1'b1;
        wait_ack();
        check($sformatf("readback at %h", a), avs_readdata, model_read(a));
        avs_read <= 1'b0;
    endtask

    task automatic step_check();
        repeat (2) @(posedge core_clk);
        check("stepPointer", {27'h0, stepPointer}, {27'h0, ptrModel[4:0]});
        check("stepCommand", {24'h0, stepCommand}, {24'h0, stepModel[ptrModel % 16]});
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        report_and_stop();
    end

    initial
    begin
        logic [5:0] qa;
        rst_n = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        stepAdvance = 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        read_check(TSQ_OFF_POINTER);
        for (int i = 0; i < 24; i++)
        begin
            qa = 6'(4 + 4 * (i % 8));
            // Later passes use single lanes so a swapped byte half cannot hide.
            write_read(qa, $random(seed), (i < 8) ? 4'hF : 4'(1 + (i % 2)));
        end
        for (int i = 0; i < 16; i++)
        begin
            bus_write(TSQ_OFF_POINTER, $random(seed), 4'h1);
            step_check();
            read_check(TSQ_OFF_POINTER);
        end
        bus_write(6'h28, $random(seed), 4'hF);
        read_check(6'h28);
        bus_write(TSQ_OFF_CONTROL, 32'h1, 4'h1);
        bus_write(6'h14, $random(seed), 4'hF);
        read_check(6'h14);
        bus_write(TSQ_OFF_POINTER, 32'h1E, 4'h1);
        bus_write(TSQ_OFF_CONTROL, 32'h3, 4'h1);
        read_check(TSQ_OFF_CONTROL);
        check("queueLocked", {31'h0, queueLocked}, 32'h1);
        bus_write(TSQ_OFF_POINTER, 32'h05, 4'h1);
        bus_write(6'h10, $random(seed), 4'hF);
        read_check(6'h10);
        read_check(TSQ_OFF_POINTER);
        @(posedge core_clk);
        stepAdvance <= 1'b1;
        repeat (3) @(posedge core_clk);
        stepAdvance <= 1'b0;
        ptrModel = (ptrModel + 3) % 32;
        step_check();
        read_check(TSQ_OFF_POINTER);
        bus_write(TSQ_OFF_CONTROL, 32'h0, 4'h1);
        bus_write(TSQ_OFF_POINTER, 32'h09, 4'h1);
        read_check(TSQ_OFF_POINTER);
        bus_write(TSQ_OFF_POINTER, 32'h1F, 4'h2);
        read_check(TSQ_OFF_POINTER);
        @(posedge core_clk);
        stepAdvance <= 1'b1;
        repeat (2) @(posedge core_clk);
        stepAdvance <= 1'b0;
        step_check();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        ptrModel = 0;
        enModel = 1'b0;
        startModel = 1'b0;
        read_check(TSQ_OFF_POINTER);
        for (int i = 0; i < 8; i++)
            read_check(6'(4 + 4 * i));
        report_and_stop();
    end
endmodule // tsq_trigger_step_queue_store_bench
